// ==== core/temp_conv_pkg.sv ====
// Purpose: Shared constants and types for the conversion control block.
// Assumes: 250 MHz mclk; 8-bit pointer and data registers.
// Notes:   Times are kept in ms; cycle counts are derived from the clock rate.
`default_nettype none
package temp_conv_pkg;
  // Pointer addresses
  localparam logic [7:0] PTR_CFG1_RD     = 8'h03;
  localparam logic [7:0] PTR_CFG1_WR     = 8'h09;
  localparam logic [7:0] PTR_RATE_RD     = 8'h04;
  localparam logic [7:0] PTR_RATE_WR     = 8'h0A;
  localparam logic [7:0] PTR_TRIGGER     = 8'h0F;
  localparam logic [7:0] PTR_ETA_SINGLE  = 8'h18;
  localparam logic [7:0] PTR_CFG2_SINGLE = 8'h1A;
  localparam logic [7:0] PTR_ETA_R1      = 8'h27;
  localparam logic [7:0] PTR_ETA_R2      = 8'h28;
  localparam logic [7:0] PTR_BETA_R1     = 8'h2A;
  localparam logic [7:0] PTR_BETA_R2     = 8'h2B;
  localparam logic [7:0] PTR_CFG2_DUAL   = 8'h3F;
  // Fields and reset values
  localparam logic [7:0] CFG1_RESET      = 8'h00;
  localparam logic [7:0] CFG1_WMASK      = 8'hE4;
  localparam int         HALT_BIT        = 6;
  localparam logic [7:0] CFG2_RESET_DUAL = 8'h3C;
  localparam logic [7:0] CFG2_RESET_ONE  = 8'h1C;
  localparam logic [7:0] CFG2_WMASK_DUAL = 8'h3C;
  localparam logic [7:0] CFG2_WMASK_ONE  = 8'h1C;
  localparam int         LOCAL_EN_BIT    = 3;
  localparam int         R1_EN_BIT       = 4;
  localparam int         R2_EN_BIT       = 5;
  localparam logic [7:0] RATE_RESET      = 8'h07;
  localparam logic [7:0] RATE_FAST_CODE  = 8'h07;
  localparam logic [7:0] ETA_RESET       = 8'h00;
  localparam logic [3:0] BETA_RESET      = 4'h8;
  localparam int         BETA_AUTO_BIT   = 3;
  localparam logic [3:0] BETA_DISABLE    = 4'h7;
  localparam logic [3:0] BETA_DIODE_CODE = 4'hF;
  // Timing
  localparam int          CLK_KHZ         = 250000;
  localparam int          MEAS_AUTO_MS    = 126;
  localparam int          MEAS_MANUAL_MS  = 93;
  localparam int          RATE_BASE_MS    = 16000;
  localparam logic [31:0] MEAS_AUTO_CYC   = 32'(MEAS_AUTO_MS * CLK_KHZ);
  localparam logic [31:0] MEAS_MANUAL_CYC = 32'(MEAS_MANUAL_MS * CLK_KHZ);
  localparam logic [31:0] RATE_BASE_CYC   = 32'(64'(RATE_BASE_MS) * 64'(CLK_KHZ));
  // Ideality factor arithmetic, Q2.14 results
  localparam int          NUM_W           = 23;
  localparam int          DEN_W           = 10;
  localparam int          Q_W             = 16;
  localparam logic [14:0] ETA_BASE_DIODE  = 15'h4083;
  localparam logic [14:0] ETA_BASE_GC     = 15'h4000;
  localparam logic [8:0]  ETA_SCALE       = 9'h12C;
  // Channels and sequencer states
  typedef enum logic [1:0] {
    CH_LOCAL   = 2'h0,
    CH_REMOTE1 = 2'h1,
    CH_REMOTE2 = 2'h2
  } chan_t;
  typedef enum logic [1:0] {
    ST_HALT = 2'b00,
    ST_MEAS = 2'b01,
    ST_GAP  = 2'b11
  } state_t;
endpackage
`default_nettype wire

// ==== core/cycle_timer.sv ====
// Purpose: Down counter that flags when a loaded interval has run out.
// Assumes: Loading zero makes it expire at once.
// Notes:   expired is combinational from the count register.
`default_nettype none
module cycle_timer #(
  parameter int W = 32
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         srst,
  // Control
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              expired
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = load_val;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign expired = (cnt_q == '0);
endmodule
`default_nettype wire

// ==== core/ratio_divider.sv ====
// Purpose: Restoring unsigned divider, one quotient bit per cycle.
// Assumes: Divisor never zero; quotient fits in Q_W bits.
// Notes:   A start while busy restarts the division.
`default_nettype none
module ratio_divider (
  // Clock and reset
  input  wire logic                              mclk,
  input  wire logic                              srst,
  // Operands
  input  wire logic                              start,
  input  wire logic [temp_conv_pkg::NUM_W-1:0]   dividend,
  input  wire logic [temp_conv_pkg::DEN_W-1:0]   divisor,
  // Result
  output logic      [temp_conv_pkg::Q_W-1:0]     quotient,
  output logic                                   done
);
  localparam int NW = temp_conv_pkg::NUM_W;
  localparam int DW = temp_conv_pkg::DEN_W;
  logic          busy_q, busy_d, done_q, done_d;
  logic [4:0]    cnt_q, cnt_d;
  logic [DW:0]   rem_q, rem_d, rem_sh;
  logic [DW-1:0] den_q, den_d;
  logic [NW-1:0] quo_q, quo_d;
  logic [temp_conv_pkg::Q_W-1:0] res_q, res_d;

  always_comb begin
    busy_d = busy_q;
    done_d = 1'b0;
    cnt_d  = cnt_q;
    rem_d  = rem_q;
    den_d  = den_q;
    quo_d  = quo_q;
    res_d  = res_q;
    rem_sh = {rem_q[DW-1:0], quo_q[NW-1]};
    if (start) begin
      busy_d = 1'b1;
      cnt_d  = 5'(NW);
      rem_d  = '0;
      den_d  = divisor;
      quo_d  = dividend;
    end else if (busy_q) begin
      if (rem_sh >= {1'b0, den_q}) begin
        rem_d = rem_sh - {1'b0, den_q};
        quo_d = {quo_q[NW-2:0], 1'b1};
      end else begin
        rem_d = rem_sh;
        quo_d = {quo_q[NW-2:0], 1'b0};
      end
      cnt_d = cnt_q - 5'h01;
      if (cnt_q == 5'h01) begin
        busy_d = 1'b0;
        done_d = 1'b1;
        res_d  = quo_d[temp_conv_pkg::Q_W-1:0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      cnt_q  <= '0;
      rem_q  <= '0;
      den_q  <= '0;
      quo_q  <= '0;
      res_q  <= '0;
    end else begin
      busy_q <= busy_d;
      done_q <= done_d;
      cnt_q  <= cnt_d;
      rem_q  <= rem_d;
      den_q  <= den_d;
      quo_q  <= quo_d;
      res_q  <= res_d;
    end
  end

  assign quotient = res_q;
  assign done     = done_q;
endmodule
`default_nettype wire

// ==== core/remote_temp_conversion_control.sv ====
// Purpose: Conversion sequencing, rate, beta and ideality control of a
//          remote-diode temperature monitor.
// Assumes: Register writes arrive as one-cycle strobes from the serial engine.
// Notes:   The analog front end measures; this block says what, when and how.
// Behaviour
// - Trigger write in halt starts one pass
// - Return to halt after that pass
// - Trigger data byte is discarded
// - Halt write aborts measurement at once
// - Rate code sets passes per second
// - Rate changes only the idle gap
// - Auto beta detects sensor type each measurement
// - Disable code assumes diode, no compensation
// - Base factor 1.008 diode, else 1.000
// - Auto readback shows chosen range, 126 ms; a detected diode reads 0xF and takes 93 ms
// - Manual ranges 0-6, all take 93 ms
// - Correction value is signed eight bit
// - Effective factor base*300/(300-correction)
// - Correction registers at variant pointers
// - Correction registers reset to zero
// - Halt bit stops and resumes continuous
// - Pass order local, remote one, remote two
`default_nettype none
module remote_temp_conversion_control #(
  parameter bit          DUAL_REMOTE     = 1'b1,
  parameter logic [31:0] MEAS_AUTO_CYC   = temp_conv_pkg::MEAS_AUTO_CYC,
  parameter logic [31:0] MEAS_MANUAL_CYC = temp_conv_pkg::MEAS_MANUAL_CYC,
  parameter logic [31:0] RATE_BASE_CYC   = temp_conv_pkg::RATE_BASE_CYC
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        srst,
  // Register port from the serial engine
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  // Measurement front end
  output logic             meas_start,
  output logic      [1:0]  meas_chan,
  output logic             meas_diode_mode,
  output logic      [2:0]  meas_beta_range,
  output logic             meas_busy,
  input  wire logic        sense_is_diode,
  input  wire logic [2:0]  sense_range,
  // Effective ideality factor for the remote channel just started
  output logic      [15:0] eta_eff,
  output logic             eta_valid,
  // Status
  output logic             halted
);
  localparam logic [7:0] CFG2_PTR   = DUAL_REMOTE ? temp_conv_pkg::PTR_CFG2_DUAL
                                                  : temp_conv_pkg::PTR_CFG2_SINGLE;
  localparam logic [7:0] CFG2_RST   = DUAL_REMOTE ? temp_conv_pkg::CFG2_RESET_DUAL
                                                  : temp_conv_pkg::CFG2_RESET_ONE;
  localparam logic [7:0] CFG2_WMASK = DUAL_REMOTE ? temp_conv_pkg::CFG2_WMASK_DUAL
                                                  : temp_conv_pkg::CFG2_WMASK_ONE;

  // Register state
  logic [7:0] cfg1_q, cfg1_d, cfg2_q, cfg2_d, rate_q, rate_d;
  logic [7:0] eta1_q, eta1_d, eta2_q, eta2_d, rdata_q, rdata_d;
  logic [3:0] beta1_q, beta1_d, beta2_q, beta2_d;
  logic [3:0] det1_q, det1_d, det2_q, det2_d;
  logic       trig_hit, abort;

  // Sequencer state
  temp_conv_pkg::state_t st_q, st_d;
  logic [1:0]  chan_q, chan_d;
  logic        oneshot_q, oneshot_d;
  logic        start_q, start_d;
  logic        diode_q, diode_d;
  logic [2:0]  range_q, range_d;

  // Launch candidate
  logic [2:0]  en_vec;
  logic [2:0]  cand;
  logic [1:0]  cand_from;
  logic [3:0]  cand_cfg;
  logic        cand_remote, cand_auto, cand_diode;
  logic [2:0]  cand_range;
  logic [31:0] cand_time, period;
  logic        launch;

  // Timers and divider hookup
  logic        mtmr_load, mtmr_exp, ptmr_load, ptmr_exp;
  logic [31:0] mtmr_val, ptmr_val;
  logic        div_start;
  logic [14:0] base_sel;
  logic [7:0]  eta_sel;
  logic [temp_conv_pkg::NUM_W-1:0] div_num;
  logic [temp_conv_pkg::DEN_W-1:0] div_den;

  // First enabled channel at or after a given index; top bit flags a hit
  function automatic logic [2:0] pick(input logic [2:0] en, input logic [1:0] from);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 2; i >= 0; i--) begin
      if (en[i] && (2'(i) >= from)) begin
        r = {1'b1, 2'(i)};
      end
    end
    return r;
  endfunction

  // Host register writes
  always_comb begin
    cfg1_d   = cfg1_q;
    cfg2_d   = cfg2_q;
    rate_d   = rate_q;
    eta1_d   = eta1_q;
    eta2_d   = eta2_q;
    beta1_d  = beta1_q;
    beta2_d  = beta2_q;
    trig_hit = 1'b0;
    abort    = 1'b0;
    if (reg_wr) begin
      case (reg_addr)
        temp_conv_pkg::PTR_CFG1_RD, temp_conv_pkg::PTR_CFG1_WR: begin
          cfg1_d = reg_wdata & temp_conv_pkg::CFG1_WMASK;
          abort  = reg_wdata[temp_conv_pkg::HALT_BIT];
        end
        temp_conv_pkg::PTR_RATE_RD, temp_conv_pkg::PTR_RATE_WR: rate_d = reg_wdata;
        temp_conv_pkg::PTR_TRIGGER:    trig_hit = 1'b1;
        CFG2_PTR:                      cfg2_d   = reg_wdata & CFG2_WMASK;
        temp_conv_pkg::PTR_ETA_SINGLE: eta1_d   = DUAL_REMOTE ? eta1_q : reg_wdata;
        temp_conv_pkg::PTR_ETA_R1:     eta1_d   = DUAL_REMOTE ? reg_wdata : eta1_q;
        temp_conv_pkg::PTR_ETA_R2:     eta2_d   = DUAL_REMOTE ? reg_wdata : eta2_q;
        temp_conv_pkg::PTR_BETA_R1:    beta1_d  = reg_wdata[3:0];
        temp_conv_pkg::PTR_BETA_R2:    beta2_d  = DUAL_REMOTE ? reg_wdata[3:0] : beta2_q;
        default: begin
        end
      endcase
    end
  end

  // Read data, one cycle behind the pointer; unmapped pointers read zero
  always_comb begin
    rdata_d = 8'h00;
    case (reg_addr)
      temp_conv_pkg::PTR_CFG1_RD: rdata_d = cfg1_q;
      temp_conv_pkg::PTR_RATE_RD: rdata_d = rate_q;
      CFG2_PTR:                   rdata_d = cfg2_q;
      temp_conv_pkg::PTR_ETA_SINGLE: rdata_d = DUAL_REMOTE ? 8'h00 : eta1_q;
      temp_conv_pkg::PTR_ETA_R1:     rdata_d = DUAL_REMOTE ? eta1_q : 8'h00;
      temp_conv_pkg::PTR_ETA_R2:     rdata_d = DUAL_REMOTE ? eta2_q : 8'h00;
      temp_conv_pkg::PTR_BETA_R1: begin
        rdata_d = {4'h0, beta1_q[temp_conv_pkg::BETA_AUTO_BIT] ? det1_q : beta1_q};
      end
      temp_conv_pkg::PTR_BETA_R2: begin
        if (DUAL_REMOTE) begin
          rdata_d = {4'h0, beta2_q[temp_conv_pkg::BETA_AUTO_BIT] ? det2_q : beta2_q};
        end
      end
      default: begin
      end
    endcase
  end

  // Launch candidate and its measurement mode
  always_comb begin
    en_vec      = {cfg2_q[temp_conv_pkg::R2_EN_BIT] & DUAL_REMOTE,
                   cfg2_q[temp_conv_pkg::R1_EN_BIT],
                   cfg2_q[temp_conv_pkg::LOCAL_EN_BIT]};
    cand_from   = (st_q == temp_conv_pkg::ST_MEAS) ? chan_q + 2'h1 : 2'h0;
    cand        = pick(en_vec, cand_from);
    cand_remote = (cand[1:0] != temp_conv_pkg::CH_LOCAL);
    cand_cfg    = (cand[1:0] == temp_conv_pkg::CH_REMOTE2) ? beta2_q : beta1_q;
    cand_auto   = cand_remote && cand_cfg[temp_conv_pkg::BETA_AUTO_BIT];
    cand_diode  = !cand_remote || (cand_cfg == temp_conv_pkg::BETA_DISABLE)
                  || (cand_auto && sense_is_diode);
    cand_range  = cand_auto ? sense_range : cand_cfg[2:0];
    cand_time   = (cand_auto && !sense_is_diode) ? MEAS_AUTO_CYC : MEAS_MANUAL_CYC;
    if (rate_q >= temp_conv_pkg::RATE_FAST_CODE) begin
      period = 32'h0000_0000;
    end else begin
      period = RATE_BASE_CYC >> rate_q[2:0];
    end
  end

  // Sequencer
  always_comb begin
    st_d      = st_q;
    chan_d    = chan_q;
    oneshot_d = oneshot_q;
    launch    = 1'b0;
    ptmr_load = 1'b0;
    ptmr_val  = period;
    if (trig_hit && cfg1_q[temp_conv_pkg::HALT_BIT] && st_q == temp_conv_pkg::ST_HALT) begin
      oneshot_d = 1'b1;
    end
    unique case (st_q)
      temp_conv_pkg::ST_HALT: begin
        if (!cfg1_q[temp_conv_pkg::HALT_BIT] || oneshot_q) begin
          ptmr_load = 1'b1;
          if (cand[2]) begin
            launch = 1'b1;
          end else if (oneshot_q) begin
            oneshot_d = 1'b0;
          end else begin
            st_d = temp_conv_pkg::ST_GAP;
          end
        end
      end
      temp_conv_pkg::ST_MEAS: begin
        if (mtmr_exp) begin
          if (cand[2]) begin
            launch = 1'b1;
          end else if (oneshot_q) begin
            oneshot_d = 1'b0;
            st_d      = temp_conv_pkg::ST_HALT;
          end else begin
            st_d = temp_conv_pkg::ST_GAP;
          end
        end
      end
      temp_conv_pkg::ST_GAP: begin
        if (cfg1_q[temp_conv_pkg::HALT_BIT]) begin
          st_d = temp_conv_pkg::ST_HALT;
        end else if (ptmr_exp) begin
          ptmr_load = 1'b1;
          launch    = cand[2];
        end
      end
      default: begin
        st_d = temp_conv_pkg::ST_HALT;
      end
    endcase
    if (launch) begin
      st_d   = temp_conv_pkg::ST_MEAS;
      chan_d = cand[1:0];
    end
    if (abort) begin
      st_d      = temp_conv_pkg::ST_HALT;
      oneshot_d = 1'b0;
      launch    = 1'b0;
      ptmr_load = 1'b1;
      ptmr_val  = 32'h0000_0000;
    end
  end

  // Launch side effects: front-end mode, detection capture, divider kick
  always_comb begin
    start_d   = launch;
    diode_d   = launch ? cand_diode : diode_q;
    range_d   = launch ? cand_range : range_q;
    mtmr_load = launch || abort;
    mtmr_val  = launch ? cand_time : 32'h0000_0000;
    det1_d    = det1_q;
    det2_d    = det2_q;
    div_start = launch && cand_remote;
    if (launch && cand_auto) begin
      if (cand[1:0] == temp_conv_pkg::CH_REMOTE2) begin
        det2_d = sense_is_diode ? temp_conv_pkg::BETA_DIODE_CODE : {1'b1, sense_range};
      end else begin
        det1_d = sense_is_diode ? temp_conv_pkg::BETA_DIODE_CODE : {1'b1, sense_range};
      end
    end
    base_sel = cand_diode ? temp_conv_pkg::ETA_BASE_DIODE : temp_conv_pkg::ETA_BASE_GC;
    eta_sel  = (cand[1:0] == temp_conv_pkg::CH_REMOTE2) ? eta2_q : eta1_q;
    div_num  = temp_conv_pkg::NUM_W'(base_sel) * temp_conv_pkg::NUM_W'(temp_conv_pkg::ETA_SCALE);
    div_den  = {1'b0, temp_conv_pkg::ETA_SCALE} - {{2{eta_sel[7]}}, eta_sel};
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      cfg1_q    <= temp_conv_pkg::CFG1_RESET;
      cfg2_q    <= CFG2_RST;
      rate_q    <= temp_conv_pkg::RATE_RESET;
      eta1_q    <= temp_conv_pkg::ETA_RESET;
      eta2_q    <= temp_conv_pkg::ETA_RESET;
      beta1_q   <= temp_conv_pkg::BETA_RESET;
      beta2_q   <= temp_conv_pkg::BETA_RESET;
      det1_q    <= temp_conv_pkg::BETA_RESET;
      det2_q    <= temp_conv_pkg::BETA_RESET;
      rdata_q   <= 8'h00;
      st_q      <= temp_conv_pkg::ST_HALT;
      chan_q    <= temp_conv_pkg::CH_LOCAL;
      oneshot_q <= 1'b0;
      start_q   <= 1'b0;
      diode_q   <= 1'b1;
      range_q   <= 3'h0;
    end else begin
      cfg1_q    <= cfg1_d;
      cfg2_q    <= cfg2_d;
      rate_q    <= rate_d;
      eta1_q    <= eta1_d;
      eta2_q    <= eta2_d;
      beta1_q   <= beta1_d;
      beta2_q   <= beta2_d;
      det1_q    <= det1_d;
      det2_q    <= det2_d;
      rdata_q   <= rdata_d;
      st_q      <= st_d;
      chan_q    <= chan_d;
      oneshot_q <= oneshot_d;
      start_q   <= start_d;
      diode_q   <= diode_d;
      range_q   <= range_d;
    end
  end

  // Per-measurement duration
  cycle_timer #(.W(32)) u_meas_timer (
    .mclk     (mclk),
    .srst     (srst),
    .load     (mtmr_load),
    .load_val (mtmr_val),
    .expired  (mtmr_exp)
  );

  // Pass period; runs during the pass so only the idle tail varies
  cycle_timer #(.W(32)) u_period_timer (
    .mclk     (mclk),
    .srst     (srst),
    .load     (ptmr_load),
    .load_val (ptmr_val),
    .expired  (ptmr_exp)
  );

  ratio_divider u_eta_div (
    .mclk     (mclk),
    .srst     (srst),
    .start    (div_start),
    .dividend (div_num),
    .divisor  (div_den),
    .quotient (eta_eff),
    .done     (eta_valid)
  );

  assign reg_rdata       = rdata_q;
  assign meas_start      = start_q;
  assign meas_chan       = chan_q;
  assign meas_diode_mode = diode_q;
  assign meas_beta_range = range_q;
  assign meas_busy       = (st_q == temp_conv_pkg::ST_MEAS);
  assign halted          = (st_q == temp_conv_pkg::ST_HALT);
endmodule
`default_nettype wire

// ==== sim/conv_checker_properties.sv ====
// Purpose: Port-level checks for the conversion control block.
// Assumes: One clock domain; synchronous active-high reset.
// Notes:   Divider answers 23 cycles after each remote start.
`default_nettype none
module conv_checker (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       srst,
  // Register port
  input wire logic       reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Front end and status
  input wire logic       meas_start,
  input wire logic [1:0] meas_chan,
  input wire logic       meas_diode_mode,
  input wire logic       meas_busy,
  input wire logic       eta_valid,
  input wire logic       halted
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  property p_once; meas_start |=> !meas_start; endproperty
  a_once: assert property (p_once) else $error("start longer than one cycle");
  property p_run; meas_start |-> meas_busy && !halted; endproperty
  a_run: assert property (p_run) else $error("start without busy");
  property p_abort; reg_wr && reg_addr == 8'h09 && reg_wdata[6] |=> !meas_busy && halted;
  endproperty
  a_abort: assert property (p_abort) else $error("halt write did not stop");
  property p_eta; meas_start && meas_chan != 2'h0 |-> ##23 eta_valid; endproperty
  a_eta: assert property (p_eta) else $error("factor not delivered");
  property p_eta_loc; meas_start && meas_chan == 2'h0 |-> ##23 !eta_valid; endproperty
  a_eta_loc: assert property (p_eta_loc) else $error("factor for local");
  property p_loc_diode; meas_start && meas_chan == 2'h0 |-> meas_diode_mode; endproperty
  a_loc_diode: assert property (p_loc_diode) else $error("local not diode");
  property p_idle; halted |-> !meas_busy; endproperty
  a_idle: assert property (p_idle) else $error("busy while halted");
  property p_wo; reg_addr == 8'h0F || reg_addr == 8'hFE |=> reg_rdata == 8'h00; endproperty
  a_wo: assert property (p_wo) else $error("trigger data readable");
endmodule
bind remote_temp_conversion_control conv_checker i_conv_checker (
  .mclk(mclk), .srst(srst), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .meas_start(meas_start), .meas_chan(meas_chan),
  .meas_diode_mode(meas_diode_mode), .meas_busy(meas_busy), .eta_valid(eta_valid),
  .halted(halted));
`default_nettype wire

// ==== sim/front_end_model.sv ====
// Purpose: Behavioural sensor front end reporting detection results.
// Assumes: The block samples detection in its launch cycle.
// Notes:   The bench chooses what kind of sensor is attached.
`default_nettype none
module front_end_model (
  // Sensor chosen by the bench
  input  wire logic       is_diode,
  input  wire logic [2:0] gc_range,
  // Detection result
  output logic            sense_is_diode,
  output logic      [2:0] sense_range
);
  timeunit 1ns;
  timeprecision 1ps;
  // type and range detection
  // A diode reports the top range so an old range never leaks through
  assign sense_is_diode = is_diode;
  assign sense_range    = is_diode ? 3'h7 : gc_range;
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// Purpose: Self-checking bench for the conversion control block.
// Assumes: Shortened timing parameters; inputs change on falling edges.
// Notes:   A monitor logs every start and factor for later judgement.
`default_nettype none
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, a); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] AUTO = 32'h28;
  localparam logic [31:0] MAN  = 32'h1E;
  localparam logic [31:0] BASE = 32'h1900;
  logic        mclk, srst, reg_wr, meas_start, meas_diode_mode, meas_busy;
  logic        sense_is_diode, eta_valid, halted, is_diode;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [1:0]  meas_chan;
  logic [2:0]  meas_beta_range, sense_range, gc_range;
  logic [15:0] eta_eff;
  int          cyc = 0, num_errors = 0, n_tests = 0, bsy = 0, q_t[$];
  logic [1:0]  q_ch[$];
  logic        q_dm[$];
  logic [2:0]  q_rg[$];
  logic [15:0] q_eta[$];
  logic [7:0]  codes[3] = '{8'h05, 8'h07, 8'h0F};

  remote_temp_conversion_control #(.MEAS_AUTO_CYC(AUTO), .MEAS_MANUAL_CYC(MAN),
    .RATE_BASE_CYC(BASE)) i_remote_temp_conversion_control (
    .mclk(mclk), .srst(srst), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .meas_start(meas_start), .meas_chan(meas_chan),
    .meas_diode_mode(meas_diode_mode), .meas_beta_range(meas_beta_range),
    .meas_busy(meas_busy), .sense_is_diode(sense_is_diode), .sense_range(sense_range),
    .eta_eff(eta_eff), .eta_valid(eta_valid), .halted(halted));
  front_end_model i_front_end_model (.is_diode(is_diode), .gc_range(gc_range),
    .sense_is_diode(sense_is_diode), .sense_range(sense_range));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc++;
    if (!srst && meas_start) begin
      q_ch.push_back(meas_chan);
      q_dm.push_back(meas_diode_mode);
      q_rg.push_back(meas_beta_range);
      q_t.push_back(cyc);
    end
    if (!srst && eta_valid) q_eta.push_back(eta_eff);
    if (meas_busy === 1'b1) bsy++;
    if (cyc == 20000) begin
      num_errors++;
      close_out();
    end
  end

  task automatic close_out;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic clr;
    q_ch.delete();
    q_dm.delete();
    q_rg.delete();
    q_t.delete();
    q_eta.delete();
    bsy = 0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk);
    reg_addr = a;
    @(negedge mclk);
    `CHK("reg_rdata", e, reg_rdata)
  endtask

  task automatic t_reset_regs;
    rd(8'h04, 8'h07);
    rd(8'h27, 8'h00);
    rd(8'h28, 8'h00);
    rd(8'h2A, 8'h08);
    rd(8'h2B, 8'h08);
    rd(8'hFE, 8'h00);
  endtask

  task automatic t_halt;
    `CHK("busy", 1'b1, meas_busy)
    wr(8'h09, 8'h40);
    `CHK("halted", 1'b1, halted)
    `CHK("busy", 1'b0, meas_busy)
    clr();
    repeat (300) @(negedge mclk);
    `CHK("starts", 0, q_ch.size())
    wr(8'h09, 8'h00);
    repeat (5) @(negedge mclk);
    `CHK("starts", 1, q_ch.size())
    wr(8'h09, 8'h40);
    // Host settles in shutdown before any trigger
    repeat (60) @(negedge mclk);
  endtask

  task automatic t_oneshot;
    wr(8'h2A, 8'h07);
    wr(8'h2B, 8'h03);
    wr(8'h27, 8'h7F);
    wr(8'h28, 8'h80);
    for (int k = 0; k < 2; k++) begin
      clr();
      wr(8'h0F, 8'hA5);
      repeat (130) @(negedge mclk);
      `CHK("starts", 3, q_ch.size())
      `CHK("halted", 1'b1, halted)
      `CHK("busy", 1, bsy >= 90 && bsy <= 93)
      for (int i = 0; i < 3; i++) `CHK("chan", 2'(i), q_ch[i])
      `CHK("diode", 3'h3, {q_dm[2], q_dm[1], q_dm[0]})
      `CHK("range", 3'h3, q_rg[2])
      `CHK("eta1", 16'h6FDE, q_eta[0])
      `CHK("eta2", 16'h2CDC, q_eta[1])
    end
    rd(8'h27, 8'h7F);
    rd(8'h28, 8'h80);
    rd(8'h18, 8'h00);
    rd(8'h0F, 8'h00);
  endtask

  task automatic t_auto(input logic d, input logic [7:0] rb, input logic [15:0] eta);
    is_diode = d;
    gc_range = 3'h5;
    wr(8'h3F, 8'h18);
    wr(8'h2A, 8'h08);
    wr(8'h27, 8'h0A);
    clr();
    wr(8'h0F, 8'h00);
    repeat (120) @(negedge mclk);
    `CHK("starts", 2, q_ch.size())
    `CHK("diode", d, q_dm[1])
    if (!d) `CHK("range", 3'h5, q_rg[1])
    `CHK("eta", eta, q_eta[0])
    `CHK("busy", 1, bsy >= (d ? 60 : 70) && bsy <= (d ? 62 : 72))
    rd(8'h2A, rb);
  endtask

  task automatic t_rate(input logic [7:0] code);
    int per;
    per = code < 8'h07 ? int'(BASE >> code) : int'(MAN);
    wr(8'h0A, code);
    rd(8'h04, code);
    clr();
    wr(8'h09, 8'h00);
    repeat (3 * per) @(negedge mclk);
    wr(8'h0F, 8'h00);
    repeat (2 * per) @(negedge mclk);
    wr(8'h09, 8'h40);
    `CHK("passes", 1, q_t.size() >= 4)
    for (int i = 1; i < q_t.size(); i++)
      `CHK("period", 1, q_t[i] - q_t[i-1] >= per && q_t[i] - q_t[i-1] <= per + 2)
    `CHK("busy", 1, bsy <= q_t.size() * (MAN + 1))
  endtask

  initial begin
    srst = 1'b1;
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    is_diode = 1'b0;
    gc_range = 3'h0;
    repeat (16) @(negedge mclk);
    srst = 1'b0;
    t_reset_regs();
    t_halt();
    t_oneshot();
    t_auto(1'b0, 8'h0D, 16'h4234);
    t_auto(1'b1, 8'h0F, 16'h42BC);
    wr(8'h3F, 8'h08);
    foreach (codes[i]) t_rate(codes[i]);
    close_out();
  end
endmodule
`default_nettype wire
